// *** irq_pkg.sv ***
/*
 * irq_pkg: register map, field positions, reset values and bus carrier types
 * for the core interrupt enable/flag block.
 * assumes an Avalon-MM slave with 32-bit data, one aligned word per register.
 */
package irq_pkg;
   localparam logic [3:0] ctrl_offset = 4'h0;
   localparam logic [3:0] pen1_offset = 4'h4;
   localparam logic [3:0] pflag1_offset = 4'h8;
   localparam logic [3:0] evt_offset = 4'hC;
   localparam int gie_bit = 7;
   localparam int peripheral_gating_enable_bit = 6;
   localparam int t0_en_bit = 5;
   localparam int edge_en_bit = 4;
   localparam int pc_en_bit = 3;
   localparam int t0_flag_bit = 2;
   localparam int edge_flag_bit = 1;
   localparam int pc_flag_bit = 0;
   localparam int evt_polarity_bit = 0;
   localparam logic [7:0] ctrl_reset = 8'h00;
   localparam logic [7:0] pen1_reset = 8'h00;
   localparam logic [7:0] pflag1_reset = 8'h00;
   localparam logic [7:0] ctrl_wr_mask = 8'hFE;
   localparam logic [15:0] vector_addr = 16'h0004;

   typedef struct packed {
      logic [3:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } bus_req_type;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } bus_rsp_type;
endpackage : irq_pkg

// *** core_irq_enable_flag_logic.sv ***
/*
 * core_irq_enable_flag_logic: control register, peripheral enable and flag
 * registers, edge pin detector and the combined request to the core.
 * assumes event inputs from peripherals are one-cycle pulses on sys_clk_in,
 * the edge pin and pin-change summary come from outside and are synchronised.
 */
// Added by the designer: the Avalon-MM register port and the address map.
// Function
// RULE1: flags set regardless of any enable
// RULE2: software clears flag before enabling
// RULE3: control bit 7 is global enable
// RULE4: control bit 6 gates peripheral interrupts
// RULE5: peripheral source needs gating enable too
// RULE6: control bit 5 enables timer0 overflow
// RULE7: control bit 2 is timer0 overflow flag
// RULE8: control bit 4 enables edge pin
// RULE9: control bit 1 is edge pin flag
// RULE10: control bit 3 enables pin change
// RULE11: bit 0 shows any pin change pending
// RULE12: summary read-only, clears with all flags
// RULE13: control bits 7..1 rw, all reset zero
// RULE14: peripheral enable all rw, reset zero
// RULE15: peripheral bit 0 timer1 overflow
// RULE16: peripheral bit 1 timer2 match
// RULE17: peripheral bit 2 capture compare
// RULE18: peripheral bit 3 sync serial
// RULE19: bits 4,5 serial tx, rx
// RULE20: peripheral bit 6 adc
// RULE21: peripheral bit 7 timer1 gate
// RULE22: accept clears global enable, vectors
// RULE23: return sets global enable again
// RULE24: polarity select picks active edge
// RULE25: request is gated or of enabled flags
`timescale 1ns/1ps
module core_irq_enable_flag_logic
   import irq_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic [3:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic timer0_overflow_in,
   input wire logic edge_pin_in,
   input wire logic pin_change_pending_in,
   input wire logic [7:0] periph_event_in,
   input wire logic irq_accept_in,
   input wire logic return_from_service_in,
   output logic irq_request_out,
   output logic vector_load_out,
   output logic [15:0] vector_addr_out
);
   bus_req_type req;
   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] pen1_q, pen1_d;
   logic [7:0] pflag1_q, pflag1_d;
   logic polarity_q, polarity_d;
   logic ack_q;
   logic edge_s1_q, edge_s2_q, edge_s3_q;
   logic pc_s1_q, pc_s2_q;
   logic vector_q;

   assign req = '{address: avs_address_in, read: avs_read_in, write: avs_write_in,
                  writedata: avs_writedata_in, byteenable: avs_byteenable_in};

   // one wait cycle per access: a simple registered answer
   assign avs_waitrequest_out = (req.read | req.write) & ~ack_q;
   wire logic take = (req.read | req.write) & ack_q;
   wire logic wr_lane0 = take & req.write & req.byteenable[0];
   wire logic wr_ctrl = wr_lane0 & (req.address == ctrl_offset);
   wire logic wr_pen1 = wr_lane0 & (req.address == pen1_offset);
   wire logic wr_pflag1 = wr_lane0 & (req.address == pflag1_offset);
   wire logic wr_evt = wr_lane0 & (req.address == evt_offset);
   wire logic [7:0] wdata = req.writedata[7:0];

   // edge pin: rising when polarity set, falling when clear
   wire logic edge_rise = edge_s2_q & ~edge_s3_q;
   wire logic edge_fall = ~edge_s2_q & edge_s3_q;
   wire logic edge_hit = polarity_q ? edge_rise : edge_fall; // [RULE24]

   // accept only while global enable set; return re-enables
   wire logic accept = irq_accept_in & irq_request_out; // [RULE22]

   // flag sets win over software writes in the same cycle
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d[7:1] = wdata[7:1]; // [RULE13]
      end
      if (timer0_overflow_in) begin
         ctrl_d[t0_flag_bit] = 1'b1; // [RULE1] [RULE7]
      end
      if (edge_hit) begin
         ctrl_d[edge_flag_bit] = 1'b1; // [RULE1] [RULE9]
      end
      if (accept) begin
         ctrl_d[gie_bit] = 1'b0; // [RULE22]
      end else if (return_from_service_in) begin
         ctrl_d[gie_bit] = 1'b1; // [RULE23]
      end
      ctrl_d[pc_flag_bit] = pc_s2_q; // [RULE11] [RULE12]
   end

   always_comb begin
      pen1_d = wr_pen1 ? wdata : pen1_q; // [RULE14]
      pflag1_d = (wr_pflag1 ? wdata : pflag1_q) | periph_event_in; // [RULE1]
      polarity_d = wr_evt ? wdata[evt_polarity_bit] : polarity_q;
   end

   wire logic [31:0] rd_mux =
      (req.address == ctrl_offset)   ? {24'h00_0000, ctrl_q} :
      (req.address == pen1_offset)   ? {24'h00_0000, pen1_q} :
      (req.address == pflag1_offset) ? {24'h00_0000, pflag1_q} :
      (req.address == evt_offset)    ? {31'h0000_0000, polarity_q} :
      32'h0000_0000;

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl_q <= ctrl_reset; // [RULE13]
         pen1_q <= pen1_reset; // [RULE14]
         pflag1_q <= pflag1_reset;
         polarity_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         pen1_q <= pen1_d;
         pflag1_q <= pflag1_d;
         polarity_q <= polarity_d;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ack_q <= 1'b0;
         avs_readdata_out <= 32'h0000_0000;
      end else begin
         ack_q <= (req.read | req.write) & ~ack_q;
         if ((req.read | req.write) & ~ack_q) begin
            avs_readdata_out <= req.read ? rd_mux : 32'h0000_0000;
         end
      end
   end

   // pins come from outside: two flops before any logic looks at them
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         edge_s1_q <= 1'b0;
         edge_s2_q <= 1'b0;
         edge_s3_q <= 1'b0;
         pc_s1_q <= 1'b0;
         pc_s2_q <= 1'b0;
      end else begin
         edge_s1_q <= edge_pin_in;
         edge_s2_q <= edge_s1_q;
         edge_s3_q <= edge_s2_q;
         pc_s1_q <= pin_change_pending_in;
         pc_s2_q <= pc_s1_q;
      end
   end

   // peripheral enable bits: 0 t1 ovf, 1 t2 match, 2 ccp, 3 sync serial,
   // 4 tx, 5 rx, 6 adc, 7 t1 gate
   wire logic periph_any = |(pen1_q & pflag1_q); // [RULE15] [RULE16] [RULE17] [RULE18] [RULE19] [RULE20] [RULE21]
   wire logic periph_req = ctrl_q[peripheral_gating_enable_bit] & periph_any; // [RULE4] [RULE5]
   wire logic core_req = (ctrl_q[t0_en_bit] & ctrl_q[t0_flag_bit]) // [RULE6]
                       | (ctrl_q[edge_en_bit] & ctrl_q[edge_flag_bit]) // [RULE8]
                       | (ctrl_q[pc_en_bit] & ctrl_q[pc_flag_bit]); // [RULE10]
   // stale flags fire at once on enable; software clears them first [RULE2]
   assign irq_request_out = ctrl_q[gie_bit] & (core_req | periph_req); // [RULE3] [RULE25]

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         vector_q <= 1'b0;
      end else begin
         vector_q <= accept; // [RULE22]
      end
   end
   assign vector_load_out = vector_q;
   assign vector_addr_out = vector_addr;

   chk_gie_blocks_req : assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      !ctrl_q[gie_bit] |-> !irq_request_out) else $error("request without global enable"); // [RULE3]
   chk_peripheral_gating_enable_gates_periph : assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (!ctrl_q[peripheral_gating_enable_bit] && !core_req) |-> !irq_request_out)
      else $error("peripheral request passed gating"); // [RULE4]
   chk_t0_flag_set : assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      timer0_overflow_in |=> ctrl_q[t0_flag_bit]) else $error("timer0 flag not set"); // [RULE7]
   chk_periph_flag_set : assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      periph_event_in[0] |=> pflag1_q[0]) else $error("peripheral flag not set"); // [RULE1]
   chk_accept_clears_gie : assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      accept |=> !ctrl_q[gie_bit] && vector_load_out) else $error("accept failed"); // [RULE22]
   chk_return_sets_gie : assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (return_from_service_in && !accept) |=> ctrl_q[gie_bit]) else $error("no re-enable"); // [RULE23]
   chk_summary_follows : assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      ##1 ctrl_q[pc_flag_bit] == $past(pc_s2_q)) else $error("summary flag wrong"); // [RULE12]
   chk_ctrl_write_takes : assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (wr_ctrl && !accept && !return_from_service_in) |=> ctrl_q[6:3] == $past(wdata[6:3]))
      else $error("control write lost"); // [RULE13]
   chk_edge_rise_flag : assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (polarity_q && edge_rise) |=> ctrl_q[edge_flag_bit]) else $error("edge not caught"); // [RULE24]
   chk_edge_fall_flag : assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (!polarity_q && edge_fall) |=> ctrl_q[edge_flag_bit]) else $error("fall not caught"); // [RULE24]

   // bus access: one wait cycle, then the answer
   sequence bus_first_cycle;
      (avs_read_in || avs_write_in) && avs_waitrequest_out;
   endsequence
   sequence bus_answer_cycle;
      !avs_waitrequest_out;
   endsequence
   chk_bus_one_wait : assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      bus_first_cycle |=> bus_answer_cycle) else $error("waitrequest held too long"); // [RULE13]

   chk_pen1_write_takes : assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      wr_pen1 |=> pen1_q == $past(wdata)) else $error("enable write lost"); // [RULE14]
   chk_ctrl_bit0_ro : assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      ##1 ctrl_q[pc_flag_bit] == $past(pc_s2_q)) else $error("summary bit written"); // [RULE13]
   chk_periph_req_path : assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (ctrl_q[gie_bit] && ctrl_q[peripheral_gating_enable_bit] && |(pen1_q & pflag1_q)) |-> irq_request_out)
      else $error("enabled peripheral not requesting"); // [RULE5]
   chk_edge_req_path : assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (ctrl_q[gie_bit] && ctrl_q[edge_en_bit] && ctrl_q[edge_flag_bit]) |-> irq_request_out)
      else $error("edge pin not requesting"); // [RULE8]
   chk_pc_req_path : assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (ctrl_q[gie_bit] && ctrl_q[pc_en_bit] && ctrl_q[pc_flag_bit]) |-> irq_request_out)
      else $error("pin change not requesting"); // [RULE10]
   chk_t0_req_path : assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (ctrl_q[gie_bit] && ctrl_q[t0_en_bit] && ctrl_q[t0_flag_bit]) |-> irq_request_out)
      else $error("timer0 not requesting"); // [RULE6]
   chk_vector_const : assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      vector_load_out |-> vector_addr_out == vector_addr) else $error("wrong vector"); // [RULE22]
endmodule : core_irq_enable_flag_logic

// *** irq_source_model.sv ***
/* irq_source_model: core sequencer and event sources facing the block.
   assumes its tasks are called right after a rising edge of the clock. */
`timescale 1ns/1ps
module irq_source_model (
   input wire logic sys_clk_in,
   input wire logic irq_request_in,
   input wire logic auto_accept_in,
   output logic timer0_overflow_out,
   output logic edge_pin_out,
   output logic pin_change_pending_out,
   output logic [7:0] periph_event_out,
   output logic irq_accept_out,
   output logic return_from_service_out
);
   initial begin
      {timer0_overflow_out, periph_event_out, return_from_service_out} = '0;
      irq_accept_out = 1'b0;
      edge_pin_out = 1'b1;
      pin_change_pending_out = 1'b0;
   end
   // one pulse only: the request must drop once taken
   always @(posedge sys_clk_in) begin
      irq_accept_out <= auto_accept_in && irq_request_in && !irq_accept_out;
   end
   task automatic pulse(input logic [7:0] pe, input logic t0);
      periph_event_out <= pe;
      timer0_overflow_out <= t0;
      @(posedge sys_clk_in);
      periph_event_out <= 8'h00;
      timer0_overflow_out <= 1'b0;
      @(posedge sys_clk_in);
   endtask : pulse
   task automatic ret();
      return_from_service_out <= 1'b1;
      @(posedge sys_clk_in);
      return_from_service_out <= 1'b0;
      @(posedge sys_clk_in);
   endtask : ret
   // pins pass two sync flops, so give them four edges
   task automatic level(input logic pin, input logic pc);
      edge_pin_out <= pin;
      pin_change_pending_out <= pc;
      repeat (4) @(posedge sys_clk_in);
   endtask : level
endmodule : irq_source_model

// *** core_irq_enable_flag_logic_tb.sv ***
/* core_irq_enable_flag_logic_tb: register, flag and request checks.
   assumes irq_pkg is compiled first and irq_source_model feeds the events. */
`timescale 1ns/1ps
module core_irq_enable_flag_logic_tb;
   import irq_pkg::*;
   logic sys_clk, rst_n, auto_acc, irq, vload, t0, pin, pc, acc, ret;
   logic [7:0] pe, rdata;
   logic [15:0] vaddr;
   bus_req_type req;
   bus_rsp_type rsp;
   // separate nets: two port drivers into one packed variable would clash
   logic [31:0] rd_w;
   logic wait_w;
   assign rsp = '{readdata: rd_w, waitrequest: wait_w};
   int bad_count, n_checks, vl_n;
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
   $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
   core_irq_enable_flag_logic dut (.sys_clk_in(sys_clk), .rst_n_in(rst_n),
      .avs_address_in(req.address), .avs_read_in(req.read), .avs_write_in(req.write),
      .avs_writedata_in(req.writedata), .avs_byteenable_in(req.byteenable),
      .avs_readdata_out(rd_w), .avs_waitrequest_out(wait_w),
      .timer0_overflow_in(t0), .edge_pin_in(pin), .pin_change_pending_in(pc),
      .periph_event_in(pe), .irq_accept_in(acc), .return_from_service_in(ret),
      .irq_request_out(irq), .vector_load_out(vload), .vector_addr_out(vaddr));
   irq_source_model m (.sys_clk_in(sys_clk), .irq_request_in(irq), .auto_accept_in(auto_acc),
      .timer0_overflow_out(t0), .edge_pin_out(pin), .pin_change_pending_out(pc),
      .periph_event_out(pe), .irq_accept_out(acc), .return_from_service_out(ret));
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) if (vload === 1'b1) vl_n++;
   task automatic finish_test();
      $display("checks %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : finish_test
   task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
      int n;
      n = 0;
      req.address <= a;
      req.write <= w;
      req.read <= !w;
      req.writedata <= {24'h00_0000, d};
      @(posedge sys_clk);
      while (rsp.waitrequest !== 1'b0 && n < 20) begin
         @(posedge sys_clk);
         n++;
      end
      if (n == 20) bad_count++;
      rdata = rsp.readdata[7:0];
      req.read <= 1'b0;
      req.write <= 1'b0;
      @(posedge sys_clk);
   endtask : bus
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      bus(a, 1'b0, 8'h00);
      `CHK(rdata, e)
   endtask : rdc
   initial begin
      req = '0;
      req.byteenable = 4'hF;
      rst_n = 1'b0;
      auto_acc = 1'b0;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      rdc(ctrl_offset, 8'h00);
      rdc(pen1_offset, 8'h00);
      bus(pen1_offset, 1'b1, 8'hA5);
      rdc(pen1_offset, 8'hA5);
      bus(ctrl_offset, 1'b1, 8'hFF);
      rdc(ctrl_offset, 8'hFE);
      rdc(4'h2, 8'h00);
      bus(ctrl_offset, 1'b1, 8'h00);
      $display("test registers done");
      m.pulse(8'h00, 1'b1);
      rdc(ctrl_offset, 8'h04);
      bus(ctrl_offset, 1'b1, 8'h24);
      `CHK(irq, 1'b0)
      bus(ctrl_offset, 1'b1, 8'hA4);
      `CHK(irq, 1'b1)
      auto_acc <= 1'b1;
      repeat (4) @(posedge sys_clk);
      auto_acc <= 1'b0;
      `CHK(vl_n, 1)
      `CHK(vaddr, vector_addr)
      rdc(ctrl_offset, 8'h24);
      m.ret();
      rdc(ctrl_offset, 8'hA4);
      bus(ctrl_offset, 1'b1, 8'h00);
      $display("test accept done");
      m.level(1'b0, 1'b0);
      rdc(ctrl_offset, 8'h02);
      bus(ctrl_offset, 1'b1, 8'h00);
      m.level(1'b1, 1'b0);
      rdc(ctrl_offset, 8'h00);
      bus(evt_offset, 1'b1, 8'h01);
      m.level(1'b0, 1'b0);
      rdc(ctrl_offset, 8'h00);
      m.level(1'b1, 1'b0);
      rdc(ctrl_offset, 8'h02);
      bus(ctrl_offset, 1'b1, 8'h92);
      `CHK(irq, 1'b1)
      bus(ctrl_offset, 1'b1, 8'h00);
      m.level(1'b1, 1'b1);
      rdc(ctrl_offset, 8'h01);
      bus(ctrl_offset, 1'b1, 8'h88);
      `CHK(irq, 1'b1)
      m.level(1'b1, 1'b0);
      rdc(ctrl_offset, 8'h88);
      `CHK(irq, 1'b0)
      $display("test pins done");
      for (int i = 0; i < 8; i++) begin
         bus(pflag1_offset, 1'b1, 8'h00);
         bus(pen1_offset, 1'b1, 8'h01 << i);
         bus(ctrl_offset, 1'b1, 8'h80);
         m.pulse(8'h01 << i, 1'b0);
         rdc(pflag1_offset, 8'h01 << i);
         `CHK(irq, 1'b0)
         bus(ctrl_offset, 1'b1, 8'hC0);
         `CHK(irq, 1'b1)
         bus(pen1_offset, 1'b1, ~(8'h01 << i));
         `CHK(irq, 1'b0)
      end
      $display("test peripherals done");
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      finish_test();
   end
endmodule : core_irq_enable_flag_logic_tb
